/* rtl/hsbc_pkg.sv */
package hsbc_pkg;
	localparam logic [7:0]  HSBC_ADDR_EVENT  = 8'h09;
	localparam logic [7:0]  HSBC_ADDR_CREDIT = 8'h0b;
	localparam logic [7:0]  HSBC_ADDR_MASK   = 8'h0d;
	localparam logic [31:0] HSBC_EVENT_RST   = 32'h0000_0000;
	localparam logic [31:0] HSBC_CREDIT_RST  = 32'h0000_7700;
	localparam logic [31:0] HSBC_MASK_RST    = 32'h0000_1d1a;
	localparam logic [7:0]  HSBC_TXC_MAX     = 8'h77;
	localparam logic [4:0]  HSBC_FOOT_SAT    = 5'h1f;
	localparam int          HSBC_BIT_TXECC   = 12;
	localparam int          HSBC_BIT_RXECC   = 11;
	localparam int          HSBC_BIT_CRC     = 10;
	localparam int          HSBC_BIT_GAP     = 8;
	localparam int          HSBC_BIT_HIPRIO  = 5;
	localparam int          HSBC_BIT_RXAV    = 4;
	localparam int          HSBC_BIT_TXRDY   = 3;
	localparam int          HSBC_BIT_LCHG    = 1;
	localparam int          HSBC_BIT_LINK    = 0;
	// Flags that may drive the interrupt pin
	localparam logic [31:0] HSBC_IRQ_CAPABLE = 32'h0000_1d1a;
	// Flags the host clears by writing one
	localparam logic [31:0] HSBC_W1C_BITS    = 32'h0000_1d0a;
	localparam logic [31:0] HSBC_MASK_RW     = 32'h0000_1d1a;
	typedef enum logic [0:0] {
		HSBC_SAF = 1'b0,
		HSBC_CUT = 1'b1
	} hsbc_rxmode_e;
endpackage

/* rtl/hsbc_sticky.sv */
module hsbc_sticky (
	input  wire logic sys_clk,  // System clock
	input  wire logic reset,    // Async reset, active high
	input  wire logic set_in,   // Hardware event
	input  wire logic clr_in,   // Host write-one
	output logic      flag_reg  // Sticky flag
);
	logic flag_next;

	// Set wins over a clear in the same cycle
	always_comb begin
		flag_next = set_in | (flag_reg & ~clr_in);
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			flag_reg <= 1'b0;
		end else begin
			flag_reg <= flag_next;
		end
	end
endmodule

/* rtl/hsbc_regs.sv */
// What this block does
// - Tx size ECC error sets bit 12, flushes
// - Rx size ECC error sets bit 11, clears
// - Generic protocol CRC error sets bit 10
// - Short-gap receive frame dropped, bit 8 set
// - Bit 5 shows high-priority frame, no irq
// - Store-forward: bit 4 while frame stored
// - Cut-through: bit 4 at threshold or end
// - High-priority frame delivered first
// - Bit 3 on tx done, optionally empty-qualified
// - Tx-ready stays until host writes one
// - Link change sets sticky bit 1
// - Bit 0 live link, no interrupt
// - Event status at 0x09, resets zero
// - Credits at 0x0B, reset 0x7700, top zero
// - Bits 15:8 free tx chunk credits
// - Footer credit saturated at 31
// - Credits start 0x77, fall when used
// - Bits 7:0 rx chunks waiting
// - Mask at 0x0D gates interrupt pin
module hsbc_regs (
	input  wire logic        sys_clk,          // System clock
	input  wire logic        reset,            // Async reset, active high
	input  wire logic [7:0]  reg_addr,         // Word address
	input  wire logic        reg_wr,           // Write strobe
	input  wire logic        reg_rd,           // Read strobe
	input  wire logic [31:0] reg_wdata,        // Write data
	output logic      [31:0] reg_rdata,        // Read data, next cycle
	input  wire logic        generic_proto,    // 1 generic, 0 chunk
	input  wire hsbc_pkg::hsbc_rxmode_e rx_mode, // Rx forwarding mode
	input  wire logic        tx_rdy_on_empty,  // Empty-qualify tx ready
	input  wire logic        tx_size_ecc_err,  // Tx size ECC pulse
	input  wire logic        rx_size_ecc_err,  // Rx size ECC pulse
	input  wire logic        host_crc_err,     // Host CRC error pulse
	input  wire logic [7:0]  rx_gap_len,       // Measured gap at frame
	input  wire logic        rx_frame_start,   // Rx frame start pulse
	input  wire logic [7:0]  rx_gap_threshold, // Minimum gap
	input  wire logic        rx_frames_lo,     // Low prio complete frame
	input  wire logic        rx_frames_hi,     // High prio complete frame
	input  wire logic [11:0] rx_fill,          // Rx bytes buffered
	input  wire logic [11:0] rx_cut_through_level, // Cut-through level
	input  wire logic        rx_eof_seen,      // Frame end byte received
	input  wire logic        tx_frame_done,    // Tx completion pulse
	input  wire logic        tx_fifo_empty,    // Tx FIFO empty level
	input  wire logic        link_pin,         // Raw link state, async
	input  wire logic        tx_chunk_take,    // Credit consumed pulse
	input  wire logic        tx_chunk_free,    // Credit returned pulse
	input  wire logic        rx_chunk_add,     // Rx chunk stored pulse
	input  wire logic        rx_chunk_read,    // Rx chunk read pulse
	output logic             tx_fifo_flush,    // Flush all tx frames
	output logic             rx_fifo_clear,    // Clear rx FIFO
	output logic             rx_frame_drop,    // Drop current frame
	output logic             rx_sel_hi,        // Deliver high prio next
	output logic      [4:0]  footer_credits,   // Footer credit field
	output logic             irq_out           // Interrupt, active high
);
	import hsbc_pkg::*;

	logic [31:0] mask_reg, mask_next;
	logic [7:0]  txc_reg, txc_next;
	logic [7:0]  rca_reg, rca_next;
	logic [31:0] rdata_next;
	logic [31:0] status;
	logic [31:0] w1c;
	logic        link_s1_reg, link_s2_reg, link_s3_reg;
	logic        hi_reg, av_reg, hi_next, av_next;
	logic        flush_reg, clr_reg, drop_reg, sel_reg, irq_next;
	logic [4:0]  foot_reg, foot_next;
	logic        gap_short, txrdy_set;
	logic        f_txecc, f_rxecc, f_crc, f_gap, f_txrdy, f_lchg;

	assign w1c = (reg_wr && reg_addr == HSBC_ADDR_EVENT) ?
		(reg_wdata & HSBC_W1C_BITS) : 32'h0000_0000;
	assign gap_short = rx_frame_start && (rx_gap_len < rx_gap_threshold);
	assign txrdy_set = generic_proto && tx_frame_done &&
		(!tx_rdy_on_empty || tx_fifo_empty);

	hsbc_sticky u_txecc (.sys_clk(sys_clk), .reset(reset),
		.set_in(tx_size_ecc_err), .clr_in(w1c[HSBC_BIT_TXECC]),
		.flag_reg(f_txecc));
	hsbc_sticky u_rxecc (.sys_clk(sys_clk), .reset(reset),
		.set_in(rx_size_ecc_err), .clr_in(w1c[HSBC_BIT_RXECC]),
		.flag_reg(f_rxecc));
	hsbc_sticky u_crc (.sys_clk(sys_clk), .reset(reset),
		.set_in(host_crc_err && generic_proto),
		.clr_in(w1c[HSBC_BIT_CRC]), .flag_reg(f_crc));
	hsbc_sticky u_gap (.sys_clk(sys_clk), .reset(reset),
		.set_in(gap_short), .clr_in(w1c[HSBC_BIT_GAP]),
		.flag_reg(f_gap));
	hsbc_sticky u_txrdy (.sys_clk(sys_clk), .reset(reset),
		.set_in(txrdy_set), .clr_in(w1c[HSBC_BIT_TXRDY]),
		.flag_reg(f_txrdy));
	hsbc_sticky u_lchg (.sys_clk(sys_clk), .reset(reset),
		.set_in(link_s2_reg != link_s3_reg),
		.clr_in(w1c[HSBC_BIT_LCHG]), .flag_reg(f_lchg));

	always_comb begin
		status = 32'h0000_0000;
		status[HSBC_BIT_TXECC]  = f_txecc;
		status[HSBC_BIT_RXECC]  = f_rxecc;
		status[HSBC_BIT_CRC]    = f_crc;
		status[HSBC_BIT_GAP]    = f_gap;
		status[HSBC_BIT_HIPRIO] = hi_reg;
		status[HSBC_BIT_RXAV]   = av_reg;
		status[HSBC_BIT_TXRDY]  = f_txrdy;
		status[HSBC_BIT_LCHG]   = f_lchg;
		status[HSBC_BIT_LINK]   = link_s3_reg;
	end

	always_comb begin
		hi_next = generic_proto && rx_frames_hi;
		if (!generic_proto) begin
			av_next = 1'b0;
		end else if (rx_mode == HSBC_SAF) begin
			av_next = rx_frames_hi || rx_frames_lo;
		end else begin
			av_next = rx_frames_hi || rx_frames_lo ||
				(rx_fill >= rx_cut_through_level) || rx_eof_seen;
		end
		mask_next = mask_reg;
		if (reg_wr && reg_addr == HSBC_ADDR_MASK) begin
			mask_next = reg_wdata & HSBC_MASK_RW;
		end
		txc_next = txc_reg;
		if (tx_chunk_take && !tx_chunk_free && txc_reg != 8'h00) begin
			txc_next = txc_reg - 8'h01;
		end else if (tx_chunk_free && !tx_chunk_take &&
				txc_reg < HSBC_TXC_MAX) begin
			txc_next = txc_reg + 8'h01;
		end
		rca_next = rca_reg;
		if (rx_chunk_add && !rx_chunk_read && rca_reg != 8'hff) begin
			rca_next = rca_reg + 8'h01;
		end else if (rx_chunk_read && !rx_chunk_add && rca_reg != 8'h00) begin
			rca_next = rca_reg - 8'h01;
		end
		foot_next = (txc_next > {3'h0, HSBC_FOOT_SAT}) ?
			HSBC_FOOT_SAT : txc_next[4:0];
		// Unmasked only where the mask bit is clear
		irq_next = |(status & HSBC_IRQ_CAPABLE & ~mask_reg);
		rdata_next = 32'h0000_0000;
		if (reg_rd) begin
			unique case (reg_addr)
				HSBC_ADDR_EVENT:  rdata_next = status;
				HSBC_ADDR_CREDIT: rdata_next =
					{16'h0000, txc_reg, rca_reg};
				HSBC_ADDR_MASK:   rdata_next = mask_reg;
				default:          rdata_next = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			link_s1_reg <= 1'b0;
			link_s2_reg <= 1'b0;
			link_s3_reg <= 1'b0;
			hi_reg      <= 1'b0;
			av_reg      <= 1'b0;
			mask_reg    <= HSBC_MASK_RST;
			txc_reg     <= HSBC_CREDIT_RST[15:8];
			rca_reg     <= HSBC_CREDIT_RST[7:0];
			foot_reg    <= HSBC_FOOT_SAT;
			reg_rdata   <= HSBC_EVENT_RST;
			flush_reg   <= 1'b0;
			clr_reg     <= 1'b0;
			drop_reg    <= 1'b0;
			sel_reg     <= 1'b0;
			irq_out     <= 1'b0;
		end else begin
			link_s1_reg <= link_pin;
			link_s2_reg <= link_s1_reg;
			link_s3_reg <= link_s2_reg;
			hi_reg      <= hi_next;
			av_reg      <= av_next;
			mask_reg    <= mask_next;
			txc_reg     <= txc_next;
			rca_reg     <= rca_next;
			foot_reg    <= foot_next;
			reg_rdata   <= rdata_next;
			flush_reg   <= tx_size_ecc_err;
			clr_reg     <= rx_size_ecc_err;
			drop_reg    <= gap_short;
			sel_reg     <= rx_frames_hi;
			irq_out     <= irq_next;
		end
	end

	assign tx_fifo_flush  = flush_reg;
	assign rx_fifo_clear  = clr_reg;
	assign rx_frame_drop  = drop_reg;
	assign rx_sel_hi      = sel_reg;
	assign footer_credits = foot_reg;

	AST_TXECC_SET: assert property (
		@(posedge sys_clk) disable iff (reset)
		tx_size_ecc_err |=> f_txecc && tx_fifo_flush)
		else $error("tx ecc flag or flush missing");
	AST_RXECC_SET: assert property (
		@(posedge sys_clk) disable iff (reset)
		rx_size_ecc_err |=> f_rxecc && rx_fifo_clear)
		else $error("rx ecc flag or clear missing");
	AST_CRC_SET: assert property (
		@(posedge sys_clk) disable iff (reset)
		host_crc_err && generic_proto |=> f_crc)
		else $error("crc error not flagged");
	AST_CRC_CHUNK: assert property (
		@(posedge sys_clk) disable iff (reset)
		!generic_proto && !f_crc |=> !f_crc)
		else $error("crc flag set in chunk protocol");
	AST_GAP_DROP: assert property (
		@(posedge sys_clk) disable iff (reset)
		gap_short |=> f_gap && rx_frame_drop)
		else $error("short gap not dropped");
	AST_NO_FALSE_DROP: assert property (
		@(posedge sys_clk) disable iff (reset)
		!rx_frame_start |=> !rx_frame_drop)
		else $error("frame dropped without a start");
	AST_HIPRIO: assert property (
		@(posedge sys_clk) disable iff (reset)
		generic_proto && rx_frames_hi |=> status[HSBC_BIT_HIPRIO])
		else $error("high priority frame not shown");
	AST_SAF_AVAIL: assert property (
		@(posedge sys_clk) disable iff (reset)
		generic_proto && rx_mode == HSBC_SAF &&
		(rx_frames_hi || rx_frames_lo) |=> status[HSBC_BIT_RXAV])
		else $error("stored frame not shown");
	AST_SAF_EMPTY: assert property (
		@(posedge sys_clk) disable iff (reset)
		rx_mode == HSBC_SAF && !rx_frames_hi && !rx_frames_lo
		|=> !status[HSBC_BIT_RXAV])
		else $error("frame shown with empty fifo");
	AST_CUT_AVAIL: assert property (
		@(posedge sys_clk) disable iff (reset)
		generic_proto && rx_mode == HSBC_CUT && (rx_eof_seen ||
		rx_fill >= rx_cut_through_level) |=> status[HSBC_BIT_RXAV])
		else $error("cut-through ready missing");
	AST_SEL_HI: assert property (
		@(posedge sys_clk) disable iff (reset)
		rx_frames_hi |=> rx_sel_hi)
		else $error("high priority not delivered first");
	AST_TXRDY_SET: assert property (
		@(posedge sys_clk) disable iff (reset)
		generic_proto && tx_frame_done && tx_fifo_empty |=> f_txrdy)
		else $error("tx ready not set on completion");
	AST_TXRDY_QUAL: assert property (
		@(posedge sys_clk) disable iff (reset)
		tx_rdy_on_empty && !tx_fifo_empty && !f_txrdy |=> !f_txrdy)
		else $error("tx ready set with frames queued");
	AST_TXRDY_HOLD: assert property (
		@(posedge sys_clk) disable iff (reset)
		f_txrdy && !w1c[HSBC_BIT_TXRDY] |=> f_txrdy)
		else $error("tx ready lost without write");
	AST_TXRDY_CLR: assert property (
		@(posedge sys_clk) disable iff (reset)
		f_txrdy && w1c[HSBC_BIT_TXRDY] && !tx_frame_done |=> !f_txrdy)
		else $error("tx ready not cleared by write");
	AST_LCHG: assert property (
		@(posedge sys_clk) disable iff (reset)
		$changed(link_s3_reg) |-> f_lchg)
		else $error("link change not flagged");
	AST_EVENT_RSVD: assert property (
		@(posedge sys_clk) disable iff (reset)
		reg_rd && reg_addr == HSBC_ADDR_EVENT
		|=> (reg_rdata & ~32'h0000_1d3b) == 32'h0000_0000)
		else $error("reserved event bits not zero");
	AST_CREDIT_RSVD: assert property (
		@(posedge sys_clk) disable iff (reset)
		reg_rd && reg_addr == HSBC_ADDR_CREDIT
		|=> reg_rdata[31:16] == 16'h0000)
		else $error("credit upper half not zero");
	AST_FOOT_SAT: assert property (
		@(posedge sys_clk) disable iff (reset)
		footer_credits == ((txc_reg > 8'h1f) ? 5'h1f : txc_reg[4:0]))
		else $error("footer credit wrong");
	AST_TXC_MAX: assert property (
		@(posedge sys_clk) disable iff (reset)
		txc_reg <= HSBC_TXC_MAX)
		else $error("credits above max");
	AST_TXC_TAKE: assert property (
		@(posedge sys_clk) disable iff (reset)
		tx_chunk_take && !tx_chunk_free && txc_reg != 8'h00
		|=> txc_reg == $past(txc_reg) - 8'h01)
		else $error("credit not consumed");
	AST_RCA_ADD: assert property (
		@(posedge sys_clk) disable iff (reset)
		rx_chunk_add && !rx_chunk_read && rca_reg != 8'hff
		|=> rca_reg == $past(rca_reg) + 8'h01)
		else $error("rx chunk not counted");
	AST_MASK_GATE: assert property (
		@(posedge sys_clk) disable iff (reset)
		(mask_reg & HSBC_IRQ_CAPABLE) == HSBC_IRQ_CAPABLE |=> !irq_out)
		else $error("masked flag drove interrupt");
	AST_IRQ: assert property (
		@(posedge sys_clk) disable iff (reset)
		##1 irq_out == $past(irq_next))
		else $error("irq does not follow flags");
	AST_NO_ZERO_CLR: assert property (
		@(posedge sys_clk) disable iff (reset)
		f_lchg && !w1c[HSBC_BIT_LCHG] |=> f_lchg)
		else $error("flag cleared by zero write");

	COV_IRQ: cover property (@(posedge sys_clk) !irq_out ##1 irq_out);
	COV_LINK: cover property (@(posedge sys_clk) $rose(link_s3_reg));
	COV_TXRDY_CLR: cover property (@(posedge sys_clk)
		f_txrdy ##1 !f_txrdy);
	COV_GAP_DROP: cover property (@(posedge sys_clk) rx_frame_drop);
	COV_CUT_AVAIL: cover property (@(posedge sys_clk)
		rx_mode == HSBC_CUT && av_reg);
endmodule

/* sim/hsbc_host_model.sv */
module hsbc_host_model (
	input  wire logic        sys_clk,   // System clock
	output logic      [7:0]  reg_addr,  // Word address
	output logic             reg_wr,    // Write strobe
	output logic             reg_rd,    // Read strobe
	output logic      [31:0] reg_wdata, // Write data
	input  wire logic [31:0] reg_rdata  // Read data
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 32'h0;
	end
	// Released lines flip so stale values never look valid
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		@(negedge sys_clk);
		d = reg_rdata;
	endtask
	// Flags are cleared only by writing ones
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~v;
	endtask
endmodule

/* sim/host_status_and_buffer_credits_tb.sv */
module host_status_and_buffer_credits_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import hsbc_pkg::*;
	logic        sys_clk = 1'b0;
	logic        reset = 1'b1;
	logic [7:0]  reg_addr;
	logic        reg_wr, reg_rd;
	logic [31:0] reg_wdata, reg_rdata, d;
	logic [4:0]  ev = 5'h0;
	logic [7:0]  rx_gap_len = 8'h00;
	logic        hi = 1'b0, link_pin = 1'b0, gp = 1'b1;
	logic        take = 1'b0, add = 1'b0;
	logic        on_empty = 1'b0, fifo_empty = 1'b1;
	logic        frames_lo = 1'b0, eof = 1'b0;
	hsbc_rxmode_e rx_mode_sel = HSBC_SAF;
	logic        tx_fifo_flush, rx_fifo_clear, rx_frame_drop, rx_sel_hi;
	logic        irq_out;
	logic [4:0]  footer_credits;
	int          n_fail = 0;
	int          cmp_count = 0;
	int          seed = 48;
	int          n, m;
	int          bits [5] = '{12, 11, 10, 8, 3};
	always #5 sys_clk = ~sys_clk;
	hsbc_host_model u_hsbc_host_model (.sys_clk, .reg_addr, .reg_wr,
		.reg_rd, .reg_wdata, .reg_rdata);
	hsbc_regs u_hsbc_regs (.sys_clk, .reset, .reg_addr, .reg_wr, .reg_rd,
		.reg_wdata, .reg_rdata, .generic_proto(gp), .rx_mode(rx_mode_sel),
		.tx_rdy_on_empty(on_empty), .tx_size_ecc_err(ev[0]),
		.rx_size_ecc_err(ev[1]), .host_crc_err(ev[2]), .rx_gap_len,
		.rx_frame_start(ev[3]), .rx_gap_threshold(8'h20),
		.rx_frames_lo(frames_lo), .rx_frames_hi(hi), .rx_fill(12'h000),
		.rx_cut_through_level(12'h040), .rx_eof_seen(eof),
		.tx_frame_done(ev[4]), .tx_fifo_empty(fifo_empty), .link_pin,
		.tx_chunk_take(take), .tx_chunk_free(1'b0), .rx_chunk_add(add),
		.rx_chunk_read(1'b0), .tx_fifo_flush, .rx_fifo_clear,
		.rx_frame_drop, .rx_sel_hi, .footer_credits, .irq_out);
	task automatic chk(input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("BAD t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	function automatic logic [31:0] foot_exp(input int c);
		return (c > 31) ? 32'h1f : 32'(c);
	endfunction
	task automatic end_of_test;
		if (n_fail == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge sys_clk);
		reset <= 1'b0;
		#1 chk(foot_exp(8'h77), footer_credits);
		u_hsbc_host_model.rd(HSBC_ADDR_EVENT, d);
		chk(32'h0, d);
		u_hsbc_host_model.wr(HSBC_ADDR_CREDIT, 32'hffff_ffff);
		u_hsbc_host_model.rd(HSBC_ADDR_CREDIT, d);
		chk(32'h0000_7700, d);
		u_hsbc_host_model.rd(8'h0a, d);
		chk(32'h0, d);
		u_hsbc_host_model.wr(HSBC_ADDR_MASK, 32'h0);
		for (int i = 0; i < 5; i++) begin
			@(posedge sys_clk) rx_gap_len <= 8'($unsigned($random(seed)) % 32);
			@(posedge sys_clk) ev <= 5'h1 << i;
			@(posedge sys_clk) ev <= 5'h0;
			#1 chk({i == 0, i == 1, i == 3},
				{tx_fifo_flush, rx_fifo_clear, rx_frame_drop});
			u_hsbc_host_model.wr(HSBC_ADDR_EVENT, ~(32'h1 << bits[i]));
			u_hsbc_host_model.rd(HSBC_ADDR_EVENT, d);
			chk(32'h1 << bits[i], d);
			chk(32'h1, irq_out);
			u_hsbc_host_model.wr(HSBC_ADDR_EVENT, 32'h1 << bits[i]);
			u_hsbc_host_model.rd(HSBC_ADDR_EVENT, d);
			chk(32'h0, d);
			chk(32'h0, irq_out);
		end
		@(posedge sys_clk) link_pin <= 1'b1;
		repeat (6) @(posedge sys_clk);
		u_hsbc_host_model.rd(HSBC_ADDR_EVENT, d);
		chk(32'h3, d);
		u_hsbc_host_model.wr(HSBC_ADDR_EVENT, 32'h3);
		u_hsbc_host_model.rd(HSBC_ADDR_EVENT, d);
		chk(32'h1, d);
		chk(32'h0, irq_out);
		@(posedge sys_clk) hi <= 1'b1;
		repeat (3) @(posedge sys_clk);
		u_hsbc_host_model.rd(HSBC_ADDR_EVENT, d);
		chk(32'h31, d);
		chk(32'h1, rx_sel_hi);
		@(posedge sys_clk) hi <= 1'b0;
		u_hsbc_host_model.wr(HSBC_ADDR_MASK, 32'h1d1a);
		@(posedge sys_clk) ev <= 5'h4;
		@(posedge sys_clk) ev <= 5'h0;
		repeat (3) @(posedge sys_clk);
		chk(32'h0, irq_out);
		// Qualified mode: no tx ready while frames still queued
		@(posedge sys_clk) on_empty <= 1'b1;
		fifo_empty <= 1'b0;
		@(posedge sys_clk) ev <= 5'h10;
		@(posedge sys_clk) ev <= 5'h0;
		u_hsbc_host_model.rd(HSBC_ADDR_EVENT, d);
		chk(32'h401, d);
		@(posedge sys_clk) fifo_empty <= 1'b1;
		@(posedge sys_clk) ev <= 5'h10;
		@(posedge sys_clk) ev <= 5'h0;
		u_hsbc_host_model.rd(HSBC_ADDR_EVENT, d);
		chk(32'h409, d);
		@(posedge sys_clk) frames_lo <= 1'b1;
		repeat (2) @(posedge sys_clk);
		u_hsbc_host_model.rd(HSBC_ADDR_EVENT, d);
		chk(32'h419, d);
		@(posedge sys_clk) frames_lo <= 1'b0;
		rx_mode_sel <= HSBC_CUT;
		repeat (2) @(posedge sys_clk);
		u_hsbc_host_model.rd(HSBC_ADDR_EVENT, d);
		chk(32'h409, d);
		@(posedge sys_clk) eof <= 1'b1;
		repeat (2) @(posedge sys_clk);
		u_hsbc_host_model.rd(HSBC_ADDR_EVENT, d);
		chk(32'h419, d);
		chk(32'h0, irq_out);
		u_hsbc_host_model.wr(HSBC_ADDR_EVENT, 32'h1d0a);
		u_hsbc_host_model.rd(HSBC_ADDR_EVENT, d);
		chk(32'h11, d);
		// Counts sit low so the footer shows the unsaturated value
		n = 100 + $unsigned($random(seed)) % 19;
		m = 1 + $unsigned($random(seed)) % 40;
		@(posedge sys_clk) gp <= 1'b0;
		for (int i = 0; i < n; i++) begin
			@(posedge sys_clk) {take, add} <= {1'b1, i < m};
			@(posedge sys_clk) {take, add} <= 2'b00;
		end
		u_hsbc_host_model.rd(HSBC_ADDR_CREDIT, d);
		chk({16'h0, 8'(8'h77 - n), 8'(m)}, d);
		chk(foot_exp(8'h77 - n), footer_credits);
		end_of_test();
	end
	initial begin
		#50000;
		n_fail++;
		end_of_test();
	end
endmodule
